/* File: hw/upsc_pkg.sv */
// Summary of operation
// R01: port 7 drive level from 0xF7 bits 5:4
// R02: ports 6,5 from 0xF7 bits 3:2,1:0
// R03: level codes: normal, low, medium, high boost
// R04: ports 4..1 from 0xF8 bits 7:6..1:0
// R05: 0xF7 clears to zero on reset
// R06: software keeps levels at 00 unless needed
// R07: swap 0: plus function on plus pin
// R08: swap 1: plus function on minus pin
// R09: swap bit 0 controls upstream port
// R10: swap bits 7,6,2,1 control ports 7,6,2,1
// R11: swap bits 3,4,5 control ports 3,4,5
package upsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int unsigned NUM_PAIRS  = 8;
  localparam int unsigned NUM_DOWN   = 7;
  localparam int unsigned LVL_W      = 2;
  localparam int unsigned LVL_CODES  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_BOOST_7_5 = 8'hF7;
  localparam logic [7:0] OFS_BOOST_4_1 = 8'hF8;
  localparam logic [7:0] OFS_PIN_SWAP  = 8'hFA;

  ////////////////////////////////////////////////////////////////////////////
  // reset values, writable bits and the read value of unmapped offsets
  localparam logic [7:0] RST_BOOST_7_5  = 8'h00;
  localparam logic [7:0] RST_BOOST_4_1  = 8'h00;
  localparam logic [7:0] RST_PIN_SWAP   = 8'h00;
  localparam logic [7:0] MASK_BOOST_7_5 = 8'h3F;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions (lsb of each two-bit level field, and the upstream swap bit)
  localparam int unsigned POS_LVL_P7 = 4;
  localparam int unsigned POS_LVL_P6 = 2;
  localparam int unsigned POS_LVL_P5 = 0;
  localparam int unsigned POS_LVL_P4 = 6;
  localparam int unsigned POS_LVL_P3 = 4;
  localparam int unsigned POS_LVL_P2 = 2;
  localparam int unsigned POS_LVL_P1 = 0;
  localparam int unsigned POS_SWAP_UP = 0;

  ////////////////////////////////////////////////////////////////////////////
  // drive level codes
  localparam logic [1:0] LVL_NORMAL = 2'h0;
  localparam logic [1:0] LVL_LOW    = 2'h1;
  localparam logic [1:0] LVL_MEDIUM = 2'h2;
  localparam logic [1:0] LVL_HIGH   = 2'h3;

endpackage

/* File: hw/upsc_pair_swap.sv */
module upsc_pair_swap (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // control
  input  wire logic swap_in,
  // transceiver side
  input  wire logic plus_func_in,
  input  wire logic plus_func_oe_in,
  input  wire logic minus_func_in,
  input  wire logic minus_func_oe_in,
  output logic      plus_func_out,
  output logic      minus_func_out,
  // pin side
  input  wire logic plus_line_pin_in,
  input  wire logic minus_line_pin_in,
  output logic      plus_line_pin_out,
  output logic      plus_line_pin_oe_out,
  output logic      minus_line_pin_out,
  output logic      minus_line_pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // transmit routing
  wire next_plus_pin     = swap_in ? minus_func_in : plus_func_in;      // R07 R08
  wire next_plus_pin_oe  = swap_in ? minus_func_oe_in : plus_func_oe_in;
  wire next_minus_pin    = swap_in ? plus_func_in : minus_func_in;      // R07 R08
  wire next_minus_pin_oe = swap_in ? plus_func_oe_in : minus_func_oe_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      plus_line_pin_out     <= 1'b0;
      plus_line_pin_oe_out  <= 1'b0;
      minus_line_pin_out    <= 1'b0;
      minus_line_pin_oe_out <= 1'b0;
    end else begin
      plus_line_pin_out     <= next_plus_pin;
      plus_line_pin_oe_out  <= next_plus_pin_oe;
      minus_line_pin_out    <= next_minus_pin;
      minus_line_pin_oe_out <= next_minus_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: three stages, a change is taken once stages two and three agree
  logic [2:0] plus_sync;
  logic [2:0] minus_sync;
  logic       plus_seen;
  logic       minus_seen;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      plus_sync  <= 3'h0;
      minus_sync <= 3'h0;
    end else begin
      plus_sync  <= {plus_sync[1:0], plus_line_pin_in};
      minus_sync <= {minus_sync[1:0], minus_line_pin_in};
    end
  end

  wire next_plus_seen  = (plus_sync[1] == plus_sync[2]) ? plus_sync[2] : plus_seen;
  wire next_minus_seen = (minus_sync[1] == minus_sync[2]) ? minus_sync[2] : minus_seen;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      plus_seen      <= 1'b0;
      minus_seen     <= 1'b0;
      plus_func_out  <= 1'b0;
      minus_func_out <= 1'b0;
    end else begin
      plus_seen      <= next_plus_seen;
      minus_seen     <= next_minus_seen;
      plus_func_out  <= swap_in ? minus_seen : plus_seen;   // R07 R08
      minus_func_out <= swap_in ? plus_seen : minus_seen;   // R07 R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_plain_route: // R07
    assert property (!swap_in |=> plus_line_pin_out == $past(plus_func_in)
                                  && minus_line_pin_out == $past(minus_func_in))
    else $error("unswapped pair not routed straight");

  a_swapped_route: // R08
    assert property (swap_in |=> plus_line_pin_out == $past(minus_func_in)
                                 && minus_line_pin_oe_out == $past(plus_func_oe_in))
    else $error("swapped pair not exchanged");

endmodule

/* File: hw/upsc_config_top.sv */
module upsc_config_top (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // configuration byte port from the loader
  input  wire logic        cfg_wr_en_in,
  input  wire logic        cfg_rd_en_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [7:0]  cfg_wdata_in,
  output logic      [7:0]  cfg_rdata_out,
  output logic             cfg_rvalid_out,
  // drive levels to the downstream transceivers
  output logic      [1:0]  drive_level_port1_out,
  output logic      [1:0]  drive_level_port2_out,
  output logic      [1:0]  drive_level_port3_out,
  output logic      [1:0]  drive_level_port4_out,
  output logic      [1:0]  drive_level_port5_out,
  output logic      [1:0]  drive_level_port6_out,
  output logic      [1:0]  drive_level_port7_out,
  output logic      [27:0] drive_boost_sel_out,
  // swap state, bit 0 upstream, bit n downstream port n
  output logic      [7:0]  pair_polarity_swap_out,
  // transceiver side of each pair, index 0 upstream
  input  wire logic [7:0]  plus_func_in,
  input  wire logic [7:0]  plus_func_oe_in,
  input  wire logic [7:0]  minus_func_in,
  input  wire logic [7:0]  minus_func_oe_in,
  output logic      [7:0]  plus_func_out,
  output logic      [7:0]  minus_func_out,
  // pins of each pair
  input  wire logic [7:0]  plus_line_pin_in,
  input  wire logic [7:0]  minus_line_pin_in,
  output logic      [7:0]  plus_line_pin_out,
  output logic      [7:0]  plus_line_pin_oe_out,
  output logic      [7:0]  minus_line_pin_out,
  output logic      [7:0]  minus_line_pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] drive_boost_ports_7_to_5;
  logic [7:0] drive_boost_ports_4_to_1;
  logic [7:0] data_pair_pin_swap;

  wire hit_boost_7_5 = cfg_addr_in == upsc_pkg::OFS_BOOST_7_5;
  wire hit_boost_4_1 = cfg_addr_in == upsc_pkg::OFS_BOOST_4_1;
  wire hit_pin_swap  = cfg_addr_in == upsc_pkg::OFS_PIN_SWAP;

  // reserved bits 7:6 are never stored, so they read back as zero
  wire [7:0] next_boost_7_5 = (cfg_wr_en_in && hit_boost_7_5) ?
                              (cfg_wdata_in & upsc_pkg::MASK_BOOST_7_5) : drive_boost_ports_7_to_5;
  wire [7:0] next_boost_4_1 = (cfg_wr_en_in && hit_boost_4_1) ? cfg_wdata_in : drive_boost_ports_4_to_1;
  wire [7:0] next_pin_swap  = (cfg_wr_en_in && hit_pin_swap) ? cfg_wdata_in : data_pair_pin_swap;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drive_boost_ports_7_to_5 <= upsc_pkg::RST_BOOST_7_5;   // R05
      drive_boost_ports_4_to_1 <= upsc_pkg::RST_BOOST_4_1;
      data_pair_pin_swap       <= upsc_pkg::RST_PIN_SWAP;
    end else begin
      drive_boost_ports_7_to_5 <= next_boost_7_5;
      drive_boost_ports_4_to_1 <= next_boost_4_1;
      data_pair_pin_swap       <= next_pin_swap;
    end
  end

  // read sees the value before a write in the same cycle
  wire [7:0] next_rdata = hit_boost_7_5 ? drive_boost_ports_7_to_5 :
                          hit_boost_4_1 ? drive_boost_ports_4_to_1 :
                          hit_pin_swap  ? data_pair_pin_swap :
                                          upsc_pkg::RDATA_UNMAPPED;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_rdata_out  <= 8'h00;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rdata_out  <= cfg_rd_en_in ? next_rdata : 8'h00;
      cfg_rvalid_out <= cfg_rd_en_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field extraction, index n is downstream port n, index 0 unused
  logic [1:0] lvl [1:7];

  assign lvl[7] = drive_boost_ports_7_to_5[upsc_pkg::POS_LVL_P7 +: upsc_pkg::LVL_W];  // R01
  assign lvl[6] = drive_boost_ports_7_to_5[upsc_pkg::POS_LVL_P6 +: upsc_pkg::LVL_W];  // R02
  assign lvl[5] = drive_boost_ports_7_to_5[upsc_pkg::POS_LVL_P5 +: upsc_pkg::LVL_W];  // R02
  assign lvl[4] = drive_boost_ports_4_to_1[upsc_pkg::POS_LVL_P4 +: upsc_pkg::LVL_W];  // R04
  assign lvl[3] = drive_boost_ports_4_to_1[upsc_pkg::POS_LVL_P3 +: upsc_pkg::LVL_W];  // R04
  assign lvl[2] = drive_boost_ports_4_to_1[upsc_pkg::POS_LVL_P2 +: upsc_pkg::LVL_W];  // R04
  assign lvl[1] = drive_boost_ports_4_to_1[upsc_pkg::POS_LVL_P1 +: upsc_pkg::LVL_W];  // R04

  ////////////////////////////////////////////////////////////////////////////
  // level outputs and one-hot boost selects, one cycle behind the register
  // the analog side wants one select line per strength, so decode here
  logic [27:0] next_boost_sel;

  for (genvar p = 1; p <= upsc_pkg::NUM_DOWN; p++) begin : g_dec
    assign next_boost_sel[(p-1)*4 +: 4] = {lvl[p] == upsc_pkg::LVL_HIGH,    // R03
                                           lvl[p] == upsc_pkg::LVL_MEDIUM,
                                           lvl[p] == upsc_pkg::LVL_LOW,
                                           lvl[p] == upsc_pkg::LVL_NORMAL};
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drive_level_port1_out  <= upsc_pkg::LVL_NORMAL;
      drive_level_port2_out  <= upsc_pkg::LVL_NORMAL;
      drive_level_port3_out  <= upsc_pkg::LVL_NORMAL;
      drive_level_port4_out  <= upsc_pkg::LVL_NORMAL;
      drive_level_port5_out  <= upsc_pkg::LVL_NORMAL;
      drive_level_port6_out  <= upsc_pkg::LVL_NORMAL;
      drive_level_port7_out  <= upsc_pkg::LVL_NORMAL;
      drive_boost_sel_out    <= 28'h1111111;
      pair_polarity_swap_out <= 8'h00;
    end else begin
      drive_level_port1_out  <= lvl[1];
      drive_level_port2_out  <= lvl[2];
      drive_level_port3_out  <= lvl[3];
      drive_level_port4_out  <= lvl[4];
      drive_level_port5_out  <= lvl[5];
      drive_level_port6_out  <= lvl[6];
      drive_level_port7_out  <= lvl[7];
      drive_boost_sel_out    <= next_boost_sel;
      pair_polarity_swap_out <= data_pair_pin_swap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pair routing, swap bit n always serves pair n (0 = upstream)
  for (genvar n = 0; n < upsc_pkg::NUM_PAIRS; n++) begin : g_pair
    upsc_pair_swap u_swap (
      .clk_in                (clk_in),
      .nrst_in               (nrst_in),
      .swap_in               (data_pair_pin_swap[n]),  // R09 R10 R11
      .plus_func_in          (plus_func_in[n]),
      .plus_func_oe_in       (plus_func_oe_in[n]),
      .minus_func_in         (minus_func_in[n]),
      .minus_func_oe_in      (minus_func_oe_in[n]),
      .plus_func_out         (plus_func_out[n]),
      .minus_func_out        (minus_func_out[n]),
      .plus_line_pin_in      (plus_line_pin_in[n]),
      .minus_line_pin_in     (minus_line_pin_in[n]),
      .plus_line_pin_out     (plus_line_pin_out[n]),
      .plus_line_pin_oe_out  (plus_line_pin_oe_out[n]),
      .minus_line_pin_out    (minus_line_pin_out[n]),
      .minus_line_pin_oe_out (minus_line_pin_oe_out[n])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_wr_7_5;
    cfg_wr_en_in && hit_boost_7_5;
  endsequence

  sequence s_wr_4_1;
    cfg_wr_en_in && hit_boost_4_1;
  endsequence

  sequence s_wr_swap;
    cfg_wr_en_in && hit_pin_swap;
  endsequence

  a_port7_level: // R01
    assert property (s_wr_7_5 ##1 !cfg_wr_en_in |=> drive_level_port7_out == $past(cfg_wdata_in[5:4], 2))
    else $error("port 7 level not taken from bits 5:4");

  a_port6_5_level: // R02
    assert property (s_wr_7_5 ##1 !cfg_wr_en_in |=> drive_level_port6_out == $past(cfg_wdata_in[3:2], 2)
                                                    && drive_level_port5_out == $past(cfg_wdata_in[1:0], 2))
    else $error("port 6 or 5 level misplaced");

  a_reserved_zero: // R02
    assert property (s_wr_7_5 |=> drive_boost_ports_7_to_5[7:6] == 2'h0)
    else $error("reserved boost bits stored");

  a_level_decode: // R03
    assert property (##1 drive_boost_sel_out[3:0] == (4'h1 << $past(lvl[1]))
                         && drive_boost_sel_out[27:24] == (4'h1 << $past(lvl[7])))
    else $error("boost select does not match level");

  a_mid_decode: // R03
    assert property (##1 drive_boost_sel_out[11:8] == (4'h1 << $past(lvl[3]))
                         && drive_boost_sel_out[19:16] == (4'h1 << $past(lvl[5])))
    else $error("boost select of port 3 or 5 wrong");

  a_ports4_1_level: // R04
    assert property (s_wr_4_1 ##1 !cfg_wr_en_in |=> {drive_level_port4_out, drive_level_port3_out,
                                                     drive_level_port2_out, drive_level_port1_out}
                                                    == $past(cfg_wdata_in, 2))
    else $error("ports 4 to 1 levels misplaced");

  a_reset_clear: // R05
    assert property (!$past(nrst_in) |-> drive_boost_ports_7_to_5 == upsc_pkg::RST_BOOST_7_5
                                         && drive_level_port7_out == upsc_pkg::LVL_NORMAL)
    else $error("boost 7:5 not clear after reset");

  a_swap_upstream: // R09
    assert property (s_wr_swap ##1 !cfg_wr_en_in |=> plus_line_pin_out[0] ==
                     ($past(cfg_wdata_in[0], 2) ? $past(minus_func_in[0]) : $past(plus_func_in[0])))
    else $error("upstream pair not steered by bit 0");

  a_swap_down_map: // R10 R11
    assert property (s_wr_swap ##1 !cfg_wr_en_in |=> pair_polarity_swap_out == $past(cfg_wdata_in, 2)
                     && minus_line_pin_out[4] ==
                     ($past(cfg_wdata_in[4], 2) ? $past(plus_func_in[4]) : $past(minus_func_in[4])))
    else $error("downstream swap bit not paired with its port");

  a_read_back: // R09 R10 R11
    assert property (cfg_rd_en_in && hit_pin_swap |=> cfg_rvalid_out && cfg_rdata_out == $past(data_pair_pin_swap))
    else $error("swap register read back wrong");

  a_reserved_read: // R02
    assert property (cfg_rd_en_in && hit_boost_7_5 |=> cfg_rvalid_out && cfg_rdata_out[7:6] == 2'h0
                     && cfg_rdata_out[5:0] == $past(drive_boost_ports_7_to_5[5:0]))
    else $error("boost 7:5 read back wrong");

endmodule

/* File: testbench/upsc_loader_model.sv */
module upsc_loader_model (
  // clock
  input  wire logic       clk_in,
  // register port towards the block
  output logic            cfg_wr_en_out,
  output logic            cfg_rd_en_out,
  output logic [7:0]      cfg_addr_out,
  output logic [7:0]      cfg_wdata_out,
  input  wire logic [7:0] cfg_rdata_in,
  input  wire logic       cfg_rvalid_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cfg_wr_en_out = 1'b0;
    cfg_rd_en_out = 1'b0;
    cfg_addr_out  = 8'h00;
    cfg_wdata_out = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle lines carry the inverse of the last value so a stale byte never looks valid
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    cfg_addr_out  = addr;
    cfg_wdata_out = data;
    cfg_wr_en_out = 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    cfg_wr_en_out = 1'b0;
    cfg_addr_out  = ~addr;
    cfg_wdata_out = ~data;
  endtask

  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(negedge clk_in);
    cfg_addr_out  = addr;
    cfg_rd_en_out = 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    cfg_rd_en_out = 1'b0;
    cfg_addr_out  = ~addr;
    n = 0;
    while (cfg_rvalid_in !== 1'b1 && n < 3) begin
      @(negedge clk_in);
      n++;
    end
    ok   = (cfg_rvalid_in === 1'b1);
    data = cfg_rdata_in;
  endtask

  // a careful loader starts every port at normal drive
  task automatic load_defaults();
    write_byte(upsc_pkg::OFS_BOOST_7_5, {2'h0, upsc_pkg::LVL_NORMAL, upsc_pkg::LVL_NORMAL, upsc_pkg::LVL_NORMAL});
    write_byte(upsc_pkg::OFS_BOOST_4_1, {4{upsc_pkg::LVL_NORMAL}});
  endtask
endmodule

/* File: testbench/tb_usb_port_drive_and_swap_config.sv */
module tb_usb_port_drive_and_swap_config;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        cfg_wr_en_in, cfg_rd_en_in, cfg_rvalid_out;
  logic [7:0]  cfg_addr_in, cfg_wdata_in, cfg_rdata_out, pair_polarity_swap_out;
  logic [1:0]  lvl [1:7];
  logic [27:0] drive_boost_sel_out;
  logic [7:0]  plus_func_in = 8'h00, minus_func_in = 8'h00;
  logic [7:0]  plus_func_oe_in = 8'h00, minus_func_oe_in = 8'h00;
  logic [7:0]  far_plus = 8'h00, far_minus = 8'h00;
  logic [7:0]  plus_func_out, minus_func_out, plus_line_pin_in, minus_line_pin_in;
  logic [7:0]  plus_line_pin_out, plus_line_pin_oe_out, minus_line_pin_out, minus_line_pin_oe_out;
  int          failures = 0;
  int          checks = 0;

  always #2 clk_in = ~clk_in;

  // wire level: the block wins where it drives, the far side elsewhere
  assign plus_line_pin_in  = (plus_line_pin_oe_out & plus_line_pin_out) | (~plus_line_pin_oe_out & far_plus);
  assign minus_line_pin_in = (minus_line_pin_oe_out & minus_line_pin_out) | (~minus_line_pin_oe_out & far_minus);

  upsc_config_top DUT (
    .clk_in, .nrst_in, .cfg_wr_en_in, .cfg_rd_en_in, .cfg_addr_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out,
    .drive_level_port1_out(lvl[1]), .drive_level_port2_out(lvl[2]), .drive_level_port3_out(lvl[3]),
    .drive_level_port4_out(lvl[4]), .drive_level_port5_out(lvl[5]), .drive_level_port6_out(lvl[6]),
    .drive_level_port7_out(lvl[7]), .drive_boost_sel_out, .pair_polarity_swap_out,
    .plus_func_in, .plus_func_oe_in, .minus_func_in, .minus_func_oe_in, .plus_func_out, .minus_func_out,
    .plus_line_pin_in, .minus_line_pin_in, .plus_line_pin_out, .plus_line_pin_oe_out,
    .minus_line_pin_out, .minus_line_pin_oe_out
  );

  upsc_loader_model loader (
    .clk_in(clk_in), .cfg_wr_en_out(cfg_wr_en_in), .cfg_rd_en_out(cfg_rd_en_in), .cfg_addr_out(cfg_addr_in),
    .cfg_wdata_out(cfg_wdata_in), .cfg_rdata_in(cfg_rdata_out), .cfg_rvalid_in(cfg_rvalid_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    loader.read_byte(addr, d, ok);
    check(32'(ok), 32'h1);
    check(32'(d), 32'(exp));
  endtask

  task automatic reset_chk();
    @(negedge clk_in);
    nrst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    for (int n = 1; n <= 7; n++) begin
      check(32'(lvl[n]), 32'h0);
    end
    check(32'(drive_boost_sel_out), 32'h1111111);
    check(32'(pair_polarity_swap_out), 32'h0);
    rd_chk(8'hF7, 8'h00);
    rd_chk(8'hF8, 8'h00);
    rd_chk(8'hFA, 8'h00);
    $display("test reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] e [1:7];
    logic [7:0] sw;
    repeat (2) @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    loader.load_defaults();
    // every code on every port, reserved bits of 0xF7 written as ones
    for (int c = 0; c < 4; c++) begin
      for (int n = 1; n <= 7; n++) begin
        e[n] = 2'(c + n);
      end
      loader.write_byte(8'hF7, {2'b11, e[7], e[6], e[5]});
      loader.write_byte(8'hF8, {e[4], e[3], e[2], e[1]});
      repeat (3) @(negedge clk_in);
      for (int n = 1; n <= 7; n++) begin
        check(32'(lvl[n]), 32'(e[n]));
        check(32'(drive_boost_sel_out[(n-1)*4 +: 4]), 32'(4'h1 << e[n]));
      end
      rd_chk(8'hF7, {2'b00, e[7], e[6], e[5]});
      rd_chk(8'hF8, {e[4], e[3], e[2], e[1]});
    end
    $display("test drive levels done");
    reset_chk();
    // unmapped offsets neither store nor disturb 0xF7
    loader.write_byte(8'hF9, 8'hFF);
    loader.write_byte(8'hF6, 8'hFF);
    rd_chk(8'hF9, 8'h00);
    rd_chk(8'hF6, 8'h00);
    rd_chk(8'hF7, 8'h00);
    $display("test unmapped done");
    // walk one swap bit, then none
    for (int k = 0; k <= 8; k++) begin
      sw = 8'(9'h1 << k);
      loader.write_byte(8'hFA, sw);
      @(negedge clk_in);
      plus_func_in     = 8'h96;
      minus_func_in    = 8'h69;
      plus_func_oe_in  = 8'hF0;
      minus_func_oe_in = 8'h0F;
      repeat (3) @(negedge clk_in);
      check(32'(pair_polarity_swap_out), 32'(sw));
      check(32'(plus_line_pin_out), 32'((8'h96 & ~sw) | (8'h69 & sw)));
      check(32'(minus_line_pin_out), 32'((8'h69 & ~sw) | (8'h96 & sw)));
      check(32'(plus_line_pin_oe_out), 32'((8'hF0 & ~sw) | (8'h0F & sw)));
      check(32'(minus_line_pin_oe_out), 32'((8'h0F & ~sw) | (8'hF0 & sw)));
      plus_func_oe_in  = 8'h00;
      minus_func_oe_in = 8'h00;
      far_plus         = 8'h5A;
      far_minus        = 8'hA5;
      repeat (8) @(negedge clk_in);
      check(32'(plus_func_out), 32'((8'h5A & ~sw) | (8'hA5 & sw)));
      check(32'(minus_func_out), 32'((8'hA5 & ~sw) | (8'h5A & sw)));
      rd_chk(8'hFA, sw);
      far_plus  = ~far_plus;
      far_minus = ~far_minus;
    end
    $display("test pin swap done");
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    failures++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
